// ==== core/flash_self_program_guard.sv ====
// Flash self-programming guard: unlock check, error flags, pointers, buffer
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_guard (
  input wire logic mclk_i, // System clock, 50 MHz
  input wire logic resetn_i, // Async reset, active low
  input wire spg_pkg::store_t store_i, // CPU peripheral store
  input wire logic [15:0] rd_addr_i, // CPU read address
  output logic [7:0] rd_data_o, // Read data, registered
  input wire logic [4:0] protect_sel_i, // Protect byte select bits
  input wire spg_pkg::flash_evt_t evt_i, // Array events
  output logic self_prog_o, // Self-programming mode
  output logic [11:0] flash_addr_o, // Current flash address
  output logic addr_match_o, // Pointer reached compare
  output logic [7:0] write_data_o, // Write buffer contents
  output logic [7:0] prog_cmd_o, // Program command register
  output logic block_protected_o, // Addressed block protected
  output logic cmd_blocked_o, // Command rejected, pulse
  output logic [2:0] err_flags_o // Status flags
);
  spg_pkg::unlock_state_t ust_r, ust_nxt;
  logic [7:0] mode_val_r;
  logic self_prog_r;
  logic [4:0] sel_r;
  logic sel_loaded_r;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic [7:0] cmp_hi_r, cmp_lo_r, wbuf_r, cmd_r, rd_r;

  wire wr = store_i.wr;
  wire [15:0] wa = store_i.addr;
  wire [7:0] wd = store_i.data;
  wire wr_key = wr && (wa == spg_pkg::ADDR_PROTECT_CMD);
  wire wr_mode = wr && (wa == spg_pkg::ADDR_MODE_CTRL);
  wire wr_stat = wr && (wa == spg_pkg::ADDR_ERR_STATUS);
  wire wr_plo = wr && (wa == spg_pkg::ADDR_PTR_LOW);
  wire wr_phi = wr && (wa == spg_pkg::ADDR_PTR_HIGH);
  wire wr_chi = wr && (wa == spg_pkg::ADDR_CMP_HIGH);
  wire wr_clo = wr && (wa == spg_pkg::ADDR_CMP_LOW);
  wire wr_buf = wr && (wa == spg_pkg::ADDR_WR_BUF);
  wire wr_cmd = wr && (wa == spg_pkg::ADDR_PROG_CMD);

  // Sequence checker; in IDLE only key and mode stores act, after the key any store advances or aborts it
  logic viol;
  logic mode_commit;
  always_comb begin
    ust_nxt = ust_r;
    viol = 1'b0;
    mode_commit = 1'b0;
    if (wr) begin
      case (ust_r)
        spg_pkg::UNL_IDLE: begin
          if (wr_key) begin
            if (wd == spg_pkg::UNLOCK_KEY) begin
              ust_nxt = spg_pkg::UNL_KEY;
            end else begin
              viol = 1'b1;
            end
          end else if (wr_mode) begin
            viol = 1'b1;
          end
        end
        spg_pkg::UNL_KEY: begin
          if (wr_mode) begin
            ust_nxt = spg_pkg::UNL_VAL;
          end else begin
            viol = 1'b1;
            ust_nxt = spg_pkg::UNL_IDLE;
          end
        end
        spg_pkg::UNL_VAL: begin
          if (wr_mode && (wd == ~mode_val_r)) begin
            ust_nxt = spg_pkg::UNL_INV;
          end else begin
            viol = 1'b1;
            ust_nxt = spg_pkg::UNL_IDLE;
          end
        end
        spg_pkg::UNL_INV: begin
          if (wr_mode && (wd == mode_val_r)) begin
            mode_commit = 1'b1;
          end else begin
            viol = 1'b1;
          end
          ust_nxt = spg_pkg::UNL_IDLE;
        end
        default: begin
          ust_nxt = spg_pkg::UNL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ust_r <= spg_pkg::UNL_IDLE;
      mode_val_r <= spg_pkg::REG_RESET;
      self_prog_r <= 1'b0;
    end else begin
      ust_r <= ust_nxt;
      if (ust_r == spg_pkg::UNL_KEY && wr_mode) begin
        mode_val_r <= wd;
      end
      if (mode_commit) begin
        self_prog_r <= wd[spg_pkg::BIT_SELF_PROG];
      end
    end
  end

  // Protect select captured once after release; reset holds SEL_PROT_NONE until then
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_r <= spg_pkg::SEL_PROT_NONE;
      sel_loaded_r <= 1'b0;
    end else if (!sel_loaded_r) begin
      sel_r <= protect_sel_i;
      sel_loaded_r <= 1'b1;
    end
  end

  // Pointer pair
  logic [11:0] ptr;
  spg_addr_counter #(.W(12)) u_ptr (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .load_lo_i(wr_plo),
    .load_hi_i(wr_phi),
    .data_i(wd),
    .step_i(evt_i.step),
    .limit_i({cmp_hi_r[3:0], cmp_lo_r}),
    .count_o(ptr),
    .match_o(addr_match_o)
  );
  assign flash_addr_o = ptr;

  // Block decode by high pointer; prohibited codes protect everything
  wire [3:0] blk = ptr[11:8];
  logic prot;
  always_comb begin
    case (sel_r)
      spg_pkg::SEL_PROT_3_0: prot = (blk <= spg_pkg::BLOCK_LAST_3);
      spg_pkg::SEL_PROT_1_0: prot = (blk <= spg_pkg::BLOCK_LAST_1);
      spg_pkg::SEL_PROT_NONE: prot = 1'b0;
      default: prot = 1'b1;
    endcase
  end
  // Protection only matters in self-programming mode
  assign block_protected_o = self_prog_r && prot;
  wire cmd_go = wr_cmd && (wd != spg_pkg::PROG_CMD_NONE) && self_prog_r;
  wire blocked = cmd_go && prot;
  assign cmd_blocked_o = blocked;

  // Sticky flags; a set in the same cycle beats a clear
  wire [2:0] set_v = {blocked | evt_i.unerased_write,
    evt_i.verify_fail | evt_i.protect_reject,
    viol};
  always_comb begin
    flags_nxt = flags_r;
    if (wr_stat) begin
      flags_nxt = flags_r & wd[2:0];
    end
    flags_nxt = flags_nxt | set_v;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_r <= 3'h0;
      cmp_hi_r <= spg_pkg::REG_RESET;
      cmp_lo_r <= spg_pkg::REG_RESET;
      wbuf_r <= spg_pkg::REG_RESET;
      cmd_r <= spg_pkg::PROG_CMD_NONE;
    end else begin
      flags_r <= flags_nxt;
      if (wr_chi) cmp_hi_r <= wd;
      if (wr_clo) cmp_lo_r <= wd;
      if (wr_buf) wbuf_r <= wd;
      if (wr_cmd) cmd_r <= wd;
    end
  end

  // Read mux; status upper bits read zero
  logic [7:0] rd_nxt;
  always_comb begin
    case (rd_addr_i)
      spg_pkg::ADDR_ERR_STATUS: rd_nxt = {5'h00, flags_r};
      spg_pkg::ADDR_MODE_CTRL: rd_nxt = {1'b0, sel_r, 1'b0, self_prog_r};
      spg_pkg::ADDR_PROG_CMD: rd_nxt = cmd_r;
      spg_pkg::ADDR_PTR_LOW: rd_nxt = ptr[7:0];
      spg_pkg::ADDR_PTR_HIGH: rd_nxt = {4'h0, ptr[11:8]};
      spg_pkg::ADDR_CMP_HIGH: rd_nxt = cmp_hi_r;
      spg_pkg::ADDR_CMP_LOW: rd_nxt = cmp_lo_r;
      spg_pkg::ADDR_WR_BUF: rd_nxt = wbuf_r;
      default: rd_nxt = 8'h00;
    endcase
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_r <= spg_pkg::REG_RESET;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign rd_data_o = rd_r;
  assign self_prog_o = self_prog_r;
  assign err_flags_o = flags_r;
  assign write_data_o = wbuf_r;
  assign prog_cmd_o = cmd_r;
endmodule
`default_nettype wire

// ==== core/spg_pkg.sv ====
// Package: register map, reset values and types of the self-program guard
package spg_pkg;
  localparam logic [15:0] ADDR_PROTECT_CMD = 16'hFFA0;
  localparam logic [15:0] ADDR_ERR_STATUS = 16'hFFA1;
  localparam logic [15:0] ADDR_MODE_CTRL = 16'hFFA2;
  localparam logic [15:0] ADDR_PROG_CMD = 16'hFFA3;
  localparam logic [15:0] ADDR_PTR_LOW = 16'hFFA4;
  localparam logic [15:0] ADDR_PTR_HIGH = 16'hFFA5;
  localparam logic [15:0] ADDR_CMP_HIGH = 16'hFFA6;
  localparam logic [15:0] ADDR_CMP_LOW = 16'hFFA7;
  localparam logic [15:0] ADDR_WR_BUF = 16'hFFA8;
  localparam logic [15:0] ADDR_PROTECT_BYTE = 16'h0081;
  localparam logic [7:0] UNLOCK_KEY = 8'hA5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int BIT_UNLOCK_VIOL = 0;
  localparam int BIT_VERIFY_ERR = 1;
  localparam int BIT_WPROT_ERR = 2;
  localparam int BIT_SELF_PROG = 0;
  localparam int SEL_LSB = 2;
  localparam logic [4:0] SEL_PROT_3_0 = 5'h0E;
  localparam logic [4:0] SEL_PROT_1_0 = 5'h0F;
  localparam logic [4:0] SEL_PROT_NONE = 5'h1F;
  localparam logic [3:0] BLOCK_LAST_3 = 4'h3;
  localparam logic [3:0] BLOCK_LAST_1 = 4'h1;
  localparam logic [7:0] PROG_CMD_NONE = 8'h00;

  typedef enum logic [1:0] {
    UNL_IDLE = 2'b00,
    UNL_KEY = 2'b01,
    UNL_VAL = 2'b11,
    UNL_INV = 2'b10
  } unlock_state_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
  } store_t;

  typedef struct packed {
    logic verify_fail;
    logic protect_reject;
    logic unerased_write;
    logic step;
  } flash_evt_t;
endpackage

// ==== core/spg_addr_counter.sv ====
// 12-bit address pointer pair counting up to its compare value
`timescale 1ns/1ps
`default_nettype none
module spg_addr_counter #(
  parameter int W = 12
) (
  input wire logic mclk_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic load_lo_i, // Load low byte
  input wire logic load_hi_i, // Load high byte
  input wire logic [7:0] data_i, // Load data
  input wire logic step_i, // Advance request from array
  input wire logic [W-1:0] limit_i, // Compare value
  output logic [W-1:0] count_o, // Current pointer
  output logic match_o // Pointer equals compare
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  assign match_o = (count_r == limit_i);
  assign count_o = count_r;
  always_comb begin
    count_nxt = count_r;
    if (load_lo_i) begin
      count_nxt[7:0] = data_i;
    end
    if (load_hi_i) begin
      count_nxt[W-1:8] = data_i[W-9:0];
    end
    if (step_i && !match_o && !load_lo_i && !load_hi_i) begin
      count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== dv/flash_self_program_guard_props.sv ====
// Checker: port-level timing of the self-program guard
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_guard_props (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire spg_pkg::store_t store_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire spg_pkg::flash_evt_t evt_i,
  input wire logic self_prog_o,
  input wire logic [11:0] flash_addr_o,
  input wire logic addr_match_o,
  input wire logic block_protected_o,
  input wire logic cmd_blocked_o,
  input wire logic [2:0] err_flags_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  wire w = store_i.wr;
  wire to_st = w && store_i.addr == spg_pkg::ADDR_ERR_STATUS;
  wire to_key = w && store_i.addr == spg_pkg::ADDR_PROTECT_CMD;
  wire to_mode = w && store_i.addr == spg_pkg::ADDR_MODE_CTRL;
  a_bad_key:
    assert property (to_key && store_i.data != spg_pkg::UNLOCK_KEY
      |=> err_flags_o[0]) else $error("bad key not flagged");
  a_verify_set:
    assert property (evt_i.verify_fail |=> err_flags_o[1])
      else $error("verify fail not flagged");
  a_unerased_set:
    assert property (evt_i.unerased_write |=> err_flags_o[2])
      else $error("unerased write not flagged");
  a_blocked_set:
    assert property (cmd_blocked_o |=> err_flags_o[2])
      else $error("blocked command not flagged");
  a_flag_sticky:
    assert property (err_flags_o[2] && !to_st |=> err_flags_o[2])
      else $error("flag dropped without clear");
  a_viol_sticky:
    assert property (err_flags_o[0] && !to_st |=> err_flags_o[0])
      else $error("violation flag dropped without clear");
  a_flag_clear:
    assert property (to_st && !store_i.data[1] && !evt_i.verify_fail &&
      !evt_i.protect_reject |=> !err_flags_o[1]) else $error("no clear");
  a_status_read:
    assert property (rd_addr_i == spg_pkg::ADDR_ERR_STATUS
      |=> rd_data_o == {5'h00, $past(err_flags_o)}) else $error("status");
  a_ptr_step:
    assert property (evt_i.step && !addr_match_o && !w
      |=> flash_addr_o == $past(flash_addr_o) + 12'h001)
      else $error("pointer did not step");
  a_prot_mode:
    assert property (!self_prog_o |-> !block_protected_o)
      else $error("protection outside self-program mode");
  a_mode_guard:
    assert property ($changed(self_prog_o) |-> $past(to_mode))
      else $error("mode changed without mode write");
endmodule
bind flash_self_program_guard flash_self_program_guard_props u_props (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .store_i(store_i),
  .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .evt_i(evt_i),
  .self_prog_o(self_prog_o), .flash_addr_o(flash_addr_o),
  .addr_match_o(addr_match_o), .block_protected_o(block_protected_o),
  .cmd_blocked_o(cmd_blocked_o), .err_flags_o(err_flags_o));
`default_nettype wire

// ==== dv/spg_flash_model.sv ====
// Flash array model: steps the pointer, reports faults at range end
`timescale 1ns/1ps
`default_nettype none
module spg_flash_model (
  input wire logic mclk_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic [7:0] prog_cmd_i, // Active command
  input wire logic match_i, // Pointer reached compare
  input wire logic [2:0] fault_i, // Verify, reject, unerased at end
  output var spg_pkg::flash_evt_t evt_o // Event pulses
);
  logic done_r;
  wire run = prog_cmd_i != spg_pkg::PROG_CMD_NONE;
  // Steps every other cycle so the guard faces a slow array
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_o <= '0;
      done_r <= 1'b0;
    end else begin
      evt_o <= '0;
      done_r <= run && match_i;
      if (run && !match_i) evt_o.step <= !evt_o.step;
      if (run && match_i && !done_r) begin
        {evt_o.verify_fail, evt_o.protect_reject} <= fault_i[2:1];
        evt_o.unerased_write <= fault_i[0];
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/test_flash_self_program_guard.sv ====
// Testbench: store sequences against the self-program guard
`timescale 1ns/1ps
`default_nettype none
module test_flash_self_program_guard;
  localparam logic [15:0] MC = spg_pkg::ADDR_MODE_CTRL;
  localparam logic [15:0] ST = spg_pkg::ADDR_ERR_STATUS;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  spg_pkg::store_t store_i = '0;
  logic [15:0] rd_addr_i = 16'h0000;
  logic [4:0] sel = spg_pkg::SEL_PROT_3_0;
  logic [2:0] fault = 3'h0;
  spg_pkg::flash_evt_t evt;
  logic self_prog, match, blk;
  logic [11:0] faddr;
  logic [7:0] rdata, wdata, cmd;
  logic [2:0] flags;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  flash_self_program_guard u_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .store_i(store_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rdata), .protect_sel_i(sel),
    .evt_i(evt), .self_prog_o(self_prog), .flash_addr_o(faddr),
    .addr_match_o(match), .write_data_o(wdata), .prog_cmd_o(cmd),
    .block_protected_o(blk), .cmd_blocked_o(), .err_flags_o(flags));
  spg_flash_model u_flash (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .prog_cmd_i(cmd), .match_i(match), .fault_i(fault), .evt_o(evt));
  initial forever #10 mclk_i = ~mclk_i;
  task automatic print_verdict();
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1 store_i = '{1'b1, a, d};
  endtask
  task automatic nop();
    @(posedge mclk_i);
    #1 store_i.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    nop();
    rd_addr_i = a;
    @(posedge mclk_i);
    #1 cmp(12'(rdata), 12'(e));
  endtask
  // Key, one store to a, two to b; a and b bend the sequence
  task automatic unl(input logic [15:0] a, input logic [7:0] v,
                     input logic [15:0] b, input logic [7:0] w, x);
    st(spg_pkg::ADDR_PROTECT_CMD, spg_pkg::UNLOCK_KEY);
    st(a, v);
    st(b, w);
    st(b, x);
    nop();
  endtask
  task automatic chk_clr(input logic [2:0] e);
    cmp(12'(flags), 12'(e));
    st(ST, 8'h00);
    nop();
    cmp(12'(flags), 12'h000);
  endtask
  task automatic rst();
    resetn_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    #1 resetn_i = 1'b1;
    repeat (2) @(posedge mclk_i);
  endtask
  initial begin
    rst();
    rd(ST, 8'h00);
    rd(MC, 8'h38);
    for (int i = 4; i < 9; i++) rd(16'hFFA0 + 16'(i), 8'h00);
    unl(MC, 8'h01, MC, 8'hFE, 8'h01);
    cmp(12'(self_prog), 12'h001);
    cmp(12'(flags), 12'h000);
    unl(MC, 8'h00, MC, 8'hFF, 8'h01);
    st(ST, 8'hFF);
    nop();
    chk_clr(3'h1);
    unl(MC, 8'h00, MC, 8'h00, 8'h00);
    chk_clr(3'h1);
    unl(MC, 8'h00, spg_pkg::ADDR_WR_BUF, 8'hFF, 8'h00);
    chk_clr(3'h1);
    unl(spg_pkg::ADDR_PTR_LOW, 8'h00, spg_pkg::ADDR_WR_BUF, 8'h00, 8'h00);
    chk_clr(3'h1);
    st(spg_pkg::ADDR_PROTECT_CMD, 8'h5A);
    nop();
    chk_clr(3'h1);
    cmp(12'(self_prog), 12'h001);
    st(spg_pkg::ADDR_PTR_HIGH, 8'h02);
    nop();
    cmp(12'(blk), 12'h001);
    st(spg_pkg::ADDR_PROG_CMD, 8'h01);
    st(spg_pkg::ADDR_PROG_CMD, 8'h00);
    nop();
    chk_clr(3'h4);
    st(spg_pkg::ADDR_PTR_HIGH, 8'h04);
    nop();
    cmp(12'(blk), 12'h000);
    st(spg_pkg::ADDR_CMP_HIGH, 8'h04);
    st(spg_pkg::ADDR_CMP_LOW, 8'h08);
    st(spg_pkg::ADDR_PTR_LOW, 8'h05);
    st(spg_pkg::ADDR_WR_BUF, 8'h5A);
    st(spg_pkg::ADDR_PROG_CMD, 8'h01);
    nop();
    cmp(12'(wdata), 12'h05A);
    cmp(12'(cmd), 12'h001);
    cmp(faddr, 12'h405);
    for (int k = 0; k < 3; k++) begin
      fault = (k == 1) ? 3'h1 : ((k == 2) ? 3'h2 : 3'h4);
      st(spg_pkg::ADDR_PTR_LOW, 8'h05);
      nop();
      for (int i = 0; i < 40 && match !== 1'b1; i++) nop();
      cmp(faddr, 12'h408);
      repeat (2) nop();
      chk_clr(k == 1 ? 3'h4 : 3'h2);
    end
    st(spg_pkg::ADDR_PROG_CMD, 8'h00);
    st(spg_pkg::ADDR_CMP_LOW, 8'h00);
    st(spg_pkg::ADDR_PTR_LOW, 8'h00);
    nop();
    cmp(12'(match), 12'h001);
    unl(MC, 8'h00, MC, 8'hFF, 8'h00);
    cmp(12'(self_prog), 12'h000);
    st(spg_pkg::ADDR_PTR_HIGH, 8'h02);
    st(spg_pkg::ADDR_PROG_CMD, 8'h01);
    st(spg_pkg::ADDR_PROG_CMD, 8'h00);
    nop();
    cmp(12'(blk), 12'h000);
    cmp(12'(flags), 12'h000);
    sel = spg_pkg::SEL_PROT_NONE;
    rst();
    rd(MC, 8'h7C);
    rd(ST, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
